// *** shared/spr_consts.svh ***
// Constants for the sector protection register block.
// Assumes a SPI mode 0 link and a 50 MHz core clock.
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH

// =====================================================================
// Command opcodes
`define SPR_OP_WRITE_ENABLE_CMD_CMD      8'h06
`define SPR_OP_WRDI_CMD      8'h04
`define SPR_OP_CLR_STATUS    8'h30
`define SPR_OP_STATUS_READ   8'h05
`define SPR_OP_MODE_READ     8'h2B
`define SPR_OP_MODE_PROG     8'h2F
`define SPR_OP_KEY_READ      8'hE7
`define SPR_OP_KEY_PROG      8'hE8
`define SPR_OP_LOCK_READ     8'hA7
`define SPR_OP_LOCK_WRITE    8'hA6
`define SPR_OP_PPB_READ3     8'hFC
`define SPR_OP_PPB_READ4     8'hE2
`define SPR_OP_PPB_PROG3     8'hFD
`define SPR_OP_PPB_PROG4     8'hE3
`define SPR_OP_PPB_ERASE     8'hE4
`define SPR_OP_DYB_READ3     8'hFA
`define SPR_OP_DYB_READ4     8'hE0
`define SPR_OP_DYB_WRITE3    8'hFB
`define SPR_OP_DYB_WRITE4    8'hE1

// =====================================================================
// Field positions
`define SPR_MODE_KEY_BIT     1
`define SPR_MODE_PERS_BIT    0
`define SPR_STAT_PERR_BIT    6
`define SPR_STAT_WEL_BIT     1
`define SPR_SECT_LSB         16

// =====================================================================
// Reset values and sizes
`define SPR_MODE_RESET       16'hFFFF
`define SPR_KEY_RESET        64'hFFFF_FFFF_FFFF_FFFF
`define SPR_BYTE_OPEN        8'hFF
`define SPR_BYTE_SHUT        8'h00
`define SPR_MODE_OPEN        2'h3
`define SPR_MODE_BOTH        2'h0
`define SPR_MODE_KEYSEL      2'h1
`define SPR_ADDR3_BYTES      4'h3
`define SPR_ADDR4_BYTES      4'h4

`endif

// *** shared/spr_pkg.sv ***
// Types for the sector protection register block.
// Assumes spr_consts.svh supplies all numbers.
package spr_pkg;

  // =====================================================================
  // Decoded command classes
  typedef enum logic [3:0] {
    SPR_K_NONE,
    SPR_K_WRITE_ENABLE_CMD,
    SPR_K_WRDI,
    SPR_K_CLSR,
    SPR_K_STAT_RD,
    SPR_K_MODE_RD,
    SPR_K_MODE_PG,
    SPR_K_KEY_RD,
    SPR_K_KEY_PG,
    SPR_K_LOCK_RD,
    SPR_K_LOCK_WR,
    SPR_K_PPB_RD,
    SPR_K_PPB_PG,
    SPR_K_PPB_ER,
    SPR_K_DYB_RD,
    SPR_K_DYB_WR
  } spr_kind_type;

  typedef logic [15:0] spr_sect_type;

endpackage

// *** tb/spr_host_model.sv ***
// Host side model: a SPI mode 0 controller issuing protection commands.
// Assumes the bench leaves at least ten core cycles between frames.
`timescale 1ns/100ps

module spr_host_model (
  output logic       o_sck,
  output logic       o_cs_n,
  output logic       o_si,
  input  wire logic  i_so,
  output logic [7:0] o_rd_data,
  output logic       o_rd_valid
);
  // =====================================================================
  // Idle: link clock still, select high
  initial begin
    o_sck      = 1'b0;
    o_cs_n     = 1'b1;
    o_si       = 1'b0;
    o_rd_data  = 8'h00;
    o_rd_valid = 1'b0;
  end

  // =====================================================================
  // One byte, MSB first, 64 ns link period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      o_si = tx[b];
      #32 o_sck = 1'b1;
      rx[b] = i_so;
      #32 o_sck = 1'b0;
    end
  endtask

  // =====================================================================
  // Whole frame: opcode, address, write data, then dummy and read bytes
  task automatic frame(input logic [7:0] op, input int nab, input logic [31:0] addr,
                       input int nwr, input logic [63:0] wd, input int nrd);
    logic [7:0] rx;
    o_cs_n = 1'b0;
    #16;
    xfer(op, rx);
    for (int i = nab - 1; i >= 0; i--) xfer(addr[8*i +: 8], rx);
    for (int i = nwr - 1; i >= 0; i--) xfer(wd[8*i +: 8], rx);
    if (nrd > 0) xfer(8'h00, rx);
    for (int i = 0; i < nrd; i++) begin
      xfer(8'h00, rx);
      o_rd_data  = rx;
      o_rd_valid = 1'b1;
      #2 o_rd_valid = 1'b0;
    end
    #16 o_cs_n = 1'b1;
    // Released data line shows no stale value
    o_si = ~o_si;
  endtask
endmodule

// *** tb/tb.sv ***
// Testbench for the sector protection register block.
// Assumes spr_host_model drives the link; expected read bytes are queued.
`timescale 1ns/100ps
`include "spr_consts.svh"

module tb;
  logic        i_core_clk;
  logic        i_reset_n;
  logic        i_hw_reset_n;
  logic [3:0]  i_query_sector;
  logic        sck, cs_n, si, so, so_oe, prot, perr, write_enable_latch, key_mode, pers_mode;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic [7:0]  exp_q[$];
  int          mismatches;
  int          n_checks;
  integer      seed;
  logic [63:0] key;

  // =====================================================================
  // Clock and instances
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  spr_sector_protect uut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_hw_reset_n(i_hw_reset_n), .i_link_sck(sck), .i_cs_n(cs_n), .i_si(si),
    .o_so(so), .o_so_oe(so_oe), .i_query_sector(i_query_sector),
    .o_sector_protected(prot), .o_prog_error(perr), .o_write_enable_latch(write_enable_latch),
    .o_key_mode(key_mode), .o_persistent_mode(pers_mode));

  spr_host_model u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid));

  // =====================================================================
  // Comparison, verdict and read monitor
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (exp_q.size() != 0) mismatches++;
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge rd_valid) begin
    #1;
    if (exp_q.size() == 0) begin
      mismatches++;
      $display("[ERR] read byte expected none seen %h", rd_data);
    end else begin
      check("read byte", rd_data, exp_q.pop_front());
    end
  end

  initial begin
    #1_000_000;
    mismatches++;
    stop_test();
  end

  // =====================================================================
  // Command helpers
  function automatic logic [31:0] sa(input logic [3:0] s);
    return {12'h000, s, 16'h0000};
  endfunction

  task automatic gap();
    repeat (12) @(posedge i_core_clk);
    #1;
  endtask

  task automatic cmd(logic [7:0] op, int nab, logic [31:0] a, int nwr, logic [63:0] wd);
    u_host.frame(op, nab, a, nwr, wd, 0);
    gap();
  endtask

  task automatic rd(logic [7:0] op, int nab, logic [31:0] a, int nrd, logic [63:0] ex);
    for (int i = nrd - 1; i >= 0; i--) exp_q.push_back(ex[8*i +: 8]);
    u_host.frame(op, nab, a, 0, 64'h0, nrd);
    gap();
  endtask

  task automatic write_enable_cmd();
    cmd(`SPR_OP_WRITE_ENABLE_CMD_CMD, 0, 0, 0, 0);
  endtask

  task automatic stat(logic pe, logic we);
    rd(`SPR_OP_STATUS_READ, 0, 0, 1, {57'h0, pe, 4'h0, we, 1'b0});
    check("program error", perr, pe);
    check("write enable latch", write_enable_latch, we);
    check("output enable idle", so_oe, 1'b0);
    cmd(`SPR_OP_CLR_STATUS, 0, 0, 0, 0);
  endtask

  task automatic query(logic [3:0] s, logic ex);
    i_query_sector = s;
    repeat (2) @(posedge i_core_clk);
    #1 check("sector protected", prot, ex);
  endtask

  task automatic pulse(input bit por);
    if (por) i_reset_n = 1'b0;
    else i_hw_reset_n = 1'b0;
    repeat (6) @(posedge i_core_clk);
    #1 i_reset_n = 1'b1;
    i_hw_reset_n = 1'b1;
    gap();
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    seed = 32'h341a_d3e0;
    mismatches = 0;
    n_checks = 0;
    i_hw_reset_n = 1'b1;
    i_query_sector = 4'h0;
    pulse(1'b1);
    rd(`SPR_OP_MODE_READ, 0, 0, 2, `SPR_MODE_RESET);
    rd(`SPR_OP_LOCK_READ, 0, 0, 1, 64'h01);
    rd(`SPR_OP_KEY_READ, 0, 0, 8, `SPR_KEY_RESET);
    for (int s = 0; s < 16; s += 5) begin
      rd(`SPR_OP_PPB_READ3, 3, sa(s), 1, `SPR_BYTE_OPEN);
      rd(`SPR_OP_DYB_READ3, 3, sa(s), 1, `SPR_BYTE_OPEN);
    end
    query(4'h3, 1'b0);
    // Persistent program ignored without write enable, then taken
    cmd(`SPR_OP_PPB_PROG3, 3, sa(3), 0, 0);
    rd(`SPR_OP_PPB_READ3, 3, sa(3), 1, `SPR_BYTE_OPEN);
    write_enable_cmd();
    stat(1'b0, 1'b1);
    write_enable_cmd();
    cmd(`SPR_OP_PPB_PROG3, 3, sa(3), 0, 0);
    stat(1'b0, 1'b0);
    write_enable_cmd();
    cmd(`SPR_OP_PPB_PROG4, 4, sa(15), 0, 0);
    rd(`SPR_OP_PPB_READ4, 4, sa(3), 1, `SPR_BYTE_SHUT);
    rd(`SPR_OP_PPB_READ3, 3, sa(15), 1, `SPR_BYTE_SHUT);
    rd(`SPR_OP_PPB_READ3, 3, sa(4), 1, `SPR_BYTE_OPEN);
    query(4'h3, 1'b1);
    // Dynamic bits through both address widths, cleared by hardware reset
    cmd(`SPR_OP_DYB_WRITE3, 3, sa(9), 1, 0);
    rd(`SPR_OP_DYB_READ4, 4, sa(9), 1, `SPR_BYTE_SHUT);
    query(4'h9, 1'b1);
    cmd(`SPR_OP_DYB_WRITE4, 4, sa(9), 1, 8'hFF);
    rd(`SPR_OP_DYB_READ3, 3, sa(9), 1, `SPR_BYTE_OPEN);
    cmd(`SPR_OP_DYB_WRITE3, 3, sa(2), 1, 0);
    pulse(1'b0);
    rd(`SPR_OP_DYB_READ3, 3, sa(2), 1, `SPR_BYTE_OPEN);
    // Erase of the whole persistent array
    write_enable_cmd();
    cmd(`SPR_OP_PPB_ERASE, 0, 0, 0, 0);
    rd(`SPR_OP_PPB_READ3, 3, sa(3), 1, `SPR_BYTE_OPEN);
    query(4'h3, 1'b0);
    // Both mode bits zero is refused
    write_enable_cmd();
    cmd(`SPR_OP_MODE_PROG, 0, 0, 2, 64'hFFF9);
    stat(1'b1, 1'b0);
    rd(`SPR_OP_MODE_READ, 0, 0, 2, `SPR_MODE_RESET);
    // Key programmed before a mode is chosen
    key = {$random(seed), $random(seed)};
    write_enable_cmd();
    cmd(`SPR_OP_KEY_PROG, 0, 0, 8, key);
    rd(`SPR_OP_KEY_READ, 0, 0, 8, key);
    // Key mode chosen during configuration
    write_enable_cmd();
    cmd(`SPR_OP_MODE_PROG, 0, 0, 2, 64'hFFFB);
    check("key mode", key_mode, 1'b1);
    rd(`SPR_OP_KEY_READ, 0, 0, 8, `SPR_KEY_RESET);
    write_enable_cmd();
    cmd(`SPR_OP_MODE_PROG, 0, 0, 2, 64'hFFFD);
    stat(1'b1, 1'b0);
    rd(`SPR_OP_MODE_READ, 0, 0, 2, 64'hFFFB);
    write_enable_cmd();
    cmd(`SPR_OP_KEY_PROG, 0, 0, 8, 0);
    stat(1'b1, 1'b0);
    pulse(1'b0);
    rd(`SPR_OP_LOCK_READ, 0, 0, 1, 64'h00);
    write_enable_cmd();
    cmd(`SPR_OP_PPB_PROG3, 3, sa(6), 0, 0);
    stat(1'b1, 1'b0);
    rd(`SPR_OP_PPB_READ3, 3, sa(6), 1, `SPR_BYTE_OPEN);
    // Persistent mode after a power-on reset
    pulse(1'b1);
    write_enable_cmd();
    cmd(`SPR_OP_MODE_PROG, 0, 0, 2, 64'hFFFD);
    check("persistent mode", pers_mode, 1'b1);
    check("key mode", key_mode, 1'b0);
    rd(`SPR_OP_LOCK_READ, 0, 0, 1, 64'h01);
    cmd(`SPR_OP_LOCK_WRITE, 0, 0, 1, 0);
    rd(`SPR_OP_LOCK_READ, 0, 0, 1, 64'h00);
    write_enable_cmd();
    cmd(`SPR_OP_PPB_PROG3, 3, sa(1), 0, 0);
    stat(1'b1, 1'b0);
    stop_test();
  end
endmodule

// *** verilog/spr_sector_protect.sv ***
// Sector protection registers behind a SPI mode 0 command link.
// Assumes the host leaves a gap of a few core cycles between frames.
`timescale 1ns/100ps
`include "spr_consts.svh"

module spr_sector_protect (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_hw_reset_n,
  input  wire logic        i_link_sck,
  input  wire logic        i_cs_n,
  input  wire logic        i_si,
  output logic             o_so,
  output logic             o_so_oe,
  input  wire logic [3:0]  i_query_sector,
  output logic             o_sector_protected,
  output logic             o_prog_error,
  output logic             o_write_enable_latch,
  output logic             o_key_mode,
  output logic             o_persistent_mode
);

  // =====================================================================
  // Command decode
  function automatic spr_pkg::spr_kind_type kind_of(input logic [7:0] op);
    spr_pkg::spr_kind_type k;
    k = spr_pkg::SPR_K_NONE;
    case (op)
      `SPR_OP_WRITE_ENABLE_CMD_CMD:    k = spr_pkg::SPR_K_WRITE_ENABLE_CMD;
      `SPR_OP_WRDI_CMD:    k = spr_pkg::SPR_K_WRDI;
      `SPR_OP_CLR_STATUS:  k = spr_pkg::SPR_K_CLSR;
      `SPR_OP_STATUS_READ: k = spr_pkg::SPR_K_STAT_RD;
      `SPR_OP_MODE_READ:   k = spr_pkg::SPR_K_MODE_RD;
      `SPR_OP_MODE_PROG:   k = spr_pkg::SPR_K_MODE_PG;
      `SPR_OP_KEY_READ:    k = spr_pkg::SPR_K_KEY_RD;
      `SPR_OP_KEY_PROG:    k = spr_pkg::SPR_K_KEY_PG;
      `SPR_OP_LOCK_READ:   k = spr_pkg::SPR_K_LOCK_RD;
      `SPR_OP_LOCK_WRITE:  k = spr_pkg::SPR_K_LOCK_WR;
      `SPR_OP_PPB_READ3,
      `SPR_OP_PPB_READ4:   k = spr_pkg::SPR_K_PPB_RD;
      `SPR_OP_PPB_PROG3,
      `SPR_OP_PPB_PROG4:   k = spr_pkg::SPR_K_PPB_PG;
      `SPR_OP_PPB_ERASE:   k = spr_pkg::SPR_K_PPB_ER;
      `SPR_OP_DYB_READ3,
      `SPR_OP_DYB_READ4:   k = spr_pkg::SPR_K_DYB_RD;
      `SPR_OP_DYB_WRITE3,
      `SPR_OP_DYB_WRITE4:  k = spr_pkg::SPR_K_DYB_WR;
      default:             k = spr_pkg::SPR_K_NONE;
    endcase
    return k;
  endfunction

  function automatic logic [3:0] addr_bytes(input logic [7:0] op);
    logic [3:0] n;
    n = 4'h0;
    if (op == `SPR_OP_PPB_READ4 || op == `SPR_OP_PPB_PROG4 ||
        op == `SPR_OP_DYB_READ4 || op == `SPR_OP_DYB_WRITE4) begin
      n = `SPR_ADDR4_BYTES;
    end else if (op == `SPR_OP_PPB_READ3 || op == `SPR_OP_PPB_PROG3 ||
                 op == `SPR_OP_DYB_READ3 || op == `SPR_OP_DYB_WRITE3) begin
      n = `SPR_ADDR3_BYTES;
    end
    return n;
  endfunction

  function automatic logic [3:0] data_bytes(input spr_pkg::spr_kind_type k);
    logic [3:0] n;
    n = 4'h0;
    case (k)
      spr_pkg::SPR_K_MODE_PG: n = 4'h2;
      spr_pkg::SPR_K_KEY_PG:  n = 4'h8;
      spr_pkg::SPR_K_LOCK_WR: n = 4'h1;
      spr_pkg::SPR_K_DYB_WR:  n = 4'h1;
      default:                n = 4'h0;
    endcase
    return n;
  endfunction

  function automatic logic is_read(input spr_pkg::spr_kind_type k);
    return k == spr_pkg::SPR_K_STAT_RD || k == spr_pkg::SPR_K_MODE_RD ||
           k == spr_pkg::SPR_K_KEY_RD  || k == spr_pkg::SPR_K_LOCK_RD ||
           k == spr_pkg::SPR_K_PPB_RD  || k == spr_pkg::SPR_K_DYB_RD;
  endfunction

  // =====================================================================
  // Link domain: byte assembly
  logic [2:0]            bit_q;
  logic [3:0]            idx_q;
  logic [6:0]            sh_q;
  logic [7:0]            op_q;
  logic [31:0]           addr_q;
  logic [63:0]           data_q;
  logic                  req_q;
  logic                  ack_s1_q;
  logic                  ack_s2_q;
  logic [63:0]           out_sh_q;
  logic                  out_en_q;
  logic                  so_q;
  logic                  so_oe_q;
  logic [63:0]           rd_word_q;
  logic                  ack_q;
  logic                  byte_done;
  logic [7:0]            byte_v;
  logic [7:0]            op_now;
  spr_pkg::spr_kind_type kind_now;
  logic [3:0]            ab_now;
  logic                  fire;

  assign byte_done = (bit_q == 3'h7);
  assign byte_v    = {sh_q, i_si};
  assign op_now    = (idx_q == 4'h0) ? byte_v : op_q;
  assign kind_now  = kind_of(op_now);
  assign ab_now    = addr_bytes(op_now);
  assign fire      = byte_done && (kind_now != spr_pkg::SPR_K_NONE) &&
                     (is_read(kind_now) ? (idx_q == ab_now)
                                        : (idx_q == ab_now + data_bytes(kind_now)));

  // Frame counters end with the frame's own select
  always_ff @(posedge i_link_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_q <= 3'h0;
      idx_q <= 4'h0;
      sh_q  <= 7'h00;
    end else begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= byte_v[6:0];
      if (byte_done && idx_q != 4'hF) begin
        idx_q <= idx_q + 4'h1;
      end
    end
  end

  // Command fields stay put after the frame for the core to take
  always_ff @(posedge i_link_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_q   <= 8'h00;
      addr_q <= 32'h0000_0000;
      data_q <= 64'h0000_0000_0000_0000;
      req_q  <= 1'b0;
    end else if (!i_cs_n && byte_done) begin
      if (idx_q == 4'h0) begin
        op_q <= byte_v;
      end else if (idx_q <= ab_now) begin
        addr_q <= {addr_q[23:0], byte_v};
      end else begin
        data_q <= {data_q[55:0], byte_v};
      end
      if (fire) begin
        req_q <= ~req_q;
      end
    end
  end

  // Read answer handshake back into the link domain
  always_ff @(posedge i_link_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // Answer shifts out after one dummy byte
  always_ff @(posedge i_link_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      out_sh_q <= 64'h0000_0000_0000_0000;
      out_en_q <= 1'b0;
    end else if (byte_done && is_read(kind_of(op_q)) && idx_q == addr_bytes(op_q) + 4'h1) begin
      out_sh_q <= (ack_s2_q == req_q) ? rd_word_q : 64'h0000_0000_0000_0000;
      out_en_q <= 1'b1;
    end else if (out_en_q) begin
      out_sh_q <= {out_sh_q[62:0], 1'b0};
    end
  end

  always_ff @(negedge i_link_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_q    <= out_sh_q[63];
      so_oe_q <= out_en_q;
    end
  end

  assign o_so    = so_q;
  assign o_so_oe = so_oe_q;

  // =====================================================================
  // Core domain: crossing and protection state
  logic                  req_s1_q;
  logic                  req_s2_q;
  logic                  req_s3_q;
  logic                  hrst_s1_q;
  logic                  hrst_s2_q;
  logic                  ev;
  logic                  hw_rst;
  spr_pkg::spr_kind_type kind;
  logic [3:0]            sect;
  logic [15:0]           mode_q;
  logic [63:0]           key_q;
  logic                  lock_q;
  spr_pkg::spr_sect_type ppb_q;
  spr_pkg::spr_sect_type dyb_q;
  logic                  wel_q;
  logic                  perr_q;
  logic                  prot_q;
  logic                  mode_open;
  logic                  nv_ok;
  logic                  mode_err;
  logic                  key_err;
  logic                  ppb_err;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_s1_q  <= 1'b0;
      req_s2_q  <= 1'b0;
      req_s3_q  <= 1'b0;
      hrst_s1_q <= 1'b1;
      hrst_s2_q <= 1'b1;
    end else begin
      req_s1_q  <= req_q;
      req_s2_q  <= req_s1_q;
      req_s3_q  <= req_s2_q;
      hrst_s1_q <= i_hw_reset_n;
      hrst_s2_q <= hrst_s1_q;
    end
  end

  assign ev        = req_s2_q ^ req_s3_q;
  assign hw_rst    = !hrst_s2_q;
  assign kind      = ev ? kind_of(op_q) : spr_pkg::SPR_K_NONE;
  assign sect      = addr_q[`SPR_SECT_LSB +: 4];
  assign mode_open = (mode_q[2:1] == `SPR_MODE_OPEN);
  assign nv_ok     = wel_q;
  assign mode_err  = kind == spr_pkg::SPR_K_MODE_PG && nv_ok &&
                     (!mode_open || data_q[2:1] == `SPR_MODE_BOTH);
  assign key_err   = kind == spr_pkg::SPR_K_KEY_PG && nv_ok && !mode_open;
  assign ppb_err   = (kind == spr_pkg::SPR_K_PPB_PG || kind == spr_pkg::SPR_K_PPB_ER) &&
                     nv_ok && !lock_q;

  // One-time mode register: bits only move from one to zero
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= `SPR_MODE_RESET;
    end else if (kind == spr_pkg::SPR_K_MODE_PG && nv_ok && !mode_err) begin
      mode_q <= mode_q & data_q[15:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_q <= `SPR_KEY_RESET;
    end else if (kind == spr_pkg::SPR_K_KEY_PG && nv_ok && !key_err) begin
      key_q <= key_q & data_q;
    end
  end

  // Lock flag: volatile, reset value follows the mode bits
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_q <= 1'b1;
    end else if (hw_rst) begin
      lock_q <= (mode_q[2:1] != `SPR_MODE_KEYSEL);
    end else if (kind == spr_pkg::SPR_K_LOCK_WR) begin
      lock_q <= lock_q & data_q[0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ppb_q <= 16'hFFFF;
    end else if (kind == spr_pkg::SPR_K_PPB_PG && nv_ok && !ppb_err) begin
      ppb_q[sect] <= 1'b0;
    end else if (kind == spr_pkg::SPR_K_PPB_ER && nv_ok && !ppb_err) begin
      ppb_q <= 16'hFFFF;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dyb_q <= 16'hFFFF;
    end else if (hw_rst) begin
      dyb_q <= 16'hFFFF;
    end else if (kind == spr_pkg::SPR_K_DYB_WR) begin
      dyb_q[sect] <= (data_q[7:0] != `SPR_BYTE_SHUT);
    end
  end

  // Write enable latch: cleared once any protected programming ends
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wel_q <= 1'b0;
    end else if (hw_rst || kind == spr_pkg::SPR_K_WRDI) begin
      wel_q <= 1'b0;
    end else if (kind == spr_pkg::SPR_K_WRITE_ENABLE_CMD) begin
      wel_q <= 1'b1;
    end else if (kind == spr_pkg::SPR_K_MODE_PG || kind == spr_pkg::SPR_K_KEY_PG ||
                 kind == spr_pkg::SPR_K_PPB_PG  || kind == spr_pkg::SPR_K_PPB_ER) begin
      wel_q <= 1'b0;
    end
  end

  // Program error flag: an error wins over clear status
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      perr_q <= 1'b0;
    end else if (mode_err || key_err || ppb_err) begin
      perr_q <= 1'b1;
    end else if (hw_rst || kind == spr_pkg::SPR_K_CLSR) begin
      perr_q <= 1'b0;
    end
  end

  // Read answers, left justified, handed to the link by a toggle
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_word_q <= 64'h0000_0000_0000_0000;
      ack_q     <= 1'b0;
    end else if (ev && is_read(kind)) begin
      ack_q <= req_s2_q;
      case (kind)
        spr_pkg::SPR_K_STAT_RD: rd_word_q <= {1'b0, perr_q, 4'h0, wel_q, 1'b0, 56'h0};
        spr_pkg::SPR_K_MODE_RD: rd_word_q <= {mode_q, 48'h0};
        spr_pkg::SPR_K_KEY_RD:  rd_word_q <= mode_q[2] ? key_q : `SPR_KEY_RESET;
        spr_pkg::SPR_K_LOCK_RD: rd_word_q <= {7'h00, lock_q, 56'h0};
        spr_pkg::SPR_K_PPB_RD:  rd_word_q <= {ppb_q[sect] ? `SPR_BYTE_OPEN
                                                          : `SPR_BYTE_SHUT, 56'h0};
        default:                rd_word_q <= {dyb_q[sect] ? `SPR_BYTE_OPEN
                                                          : `SPR_BYTE_SHUT, 56'h0};
      endcase
    end
  end

  // Sector guard seen by the array controller
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prot_q <= 1'b0;
    end else begin
      prot_q <= !ppb_q[i_query_sector] || !dyb_q[i_query_sector];
    end
  end

  assign o_sector_protected   = prot_q;
  assign o_prog_error         = perr_q;
  assign o_write_enable_latch = wel_q;
  assign o_key_mode           = !mode_q[2];
  assign o_persistent_mode    = !mode_q[1];

  // =====================================================================
  // Checks
  sequence s_mode_prog;
    ev && kind == spr_pkg::SPR_K_MODE_PG && wel_q;
  endsequence

  sequence s_ppb_prog_locked;
    ev && kind == spr_pkg::SPR_K_PPB_PG && wel_q && !lock_q;
  endsequence

  a_mode_frozen: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !mode_open |=> $stable(mode_q)) else $error("Mode register changed after selection");
  a_mode_exclusive: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    mode_q[2:1] != `SPR_MODE_BOTH) else $error("Both mode lock bits zero");
  a_mode_closed_err: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    s_mode_prog ##0 !mode_open |=> perr_q && !wel_q)
    else $error("Closed mode programming not flagged");
  a_mode_both_err: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    s_mode_prog ##0 data_q[2:1] == `SPR_MODE_BOTH |=> perr_q && $stable(mode_q))
    else $error("Double mode selection not rejected");
  a_key_hidden: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ev && kind == spr_pkg::SPR_K_KEY_RD && !mode_q[2] |=> rd_word_q == `SPR_KEY_RESET)
    else $error("Key readable in key mode");
  a_lock_guards: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    s_ppb_prog_locked |=> perr_q && $stable(ppb_q)) else $error("Persistent bit programmed");
  a_dyn_default: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    hw_rst |=> dyb_q == 16'hFFFF) else $error("Dynamic bits not reset to open");
  a_lock_default: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    hw_rst |=> lock_q == ($past(mode_q[2:1]) != `SPR_MODE_KEYSEL))
    else $error("Lock flag reset value wrong");
  a_sector_guard: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ##1 prot_q == (!$past(ppb_q[i_query_sector]) || !$past(dyb_q[i_query_sector])))
    else $error("Sector guard mismatch");

endmodule
